// ### rtl/opas_pkg.sv
package opas_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses of 32-bit words; index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_IDX   = 8'h1B;
    localparam logic [7:0] REG_SRC_IDX    = 8'h1C;
    localparam logic [9:0] ADDR_CTRL      = {REG_CTRL_IDX, 2'b00};
    localparam logic [9:0] ADDR_SRC       = {REG_SRC_IDX, 2'b00};
    localparam logic [9:0] ADDR_STATUS    = 10'h100;
    localparam logic [9:0] ADDR_MASK      = 10'h104;
    localparam logic [9:0] ADDR_PINCFG    = 10'h108;
    localparam logic [9:0] ADDR_PARTIC    = 10'h10C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RST_BIT   = 7;
    localparam int CTRL_SOFT_TRIGGER_BIT_BIT  = 6;
    localparam int CTRL_ARM_BIT   = 5;
    localparam int CTRL_TRIGGER_POLARITY_INVERT_BIT  = 1;
    localparam int CTRL_MODE_BIT  = 0;
    localparam int SRC_ARM_LSB    = 4;
    localparam int SRC_TRG_LSB    = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SRC_RESET  = 8'h00;

    // Status bits: 0 armed (live), sticky 1 armed event, 2 done, 3 bad code
    localparam int ST_ARMED_BIT = 0;
    localparam int ST_ARMEV_BIT = 1;
    localparam int ST_DONE_BIT  = 2;
    localparam int ST_BAD_BIT   = 3;
    localparam int ST_W         = 4;

    // ------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------
    localparam logic [3:0] ARM_ALWAYS = 4'h0;
    localparam logic [3:0] ARM_SOFT   = 4'h1;
    localparam logic [3:0] SRC_PLL_A  = 4'h2;
    localparam logic [3:0] TRG_SOFT   = 4'h0;
    localparam logic [3:0] SRC_PLL_T  = 4'h1;
    localparam logic [3:0] SRC_PIN0   = 4'h8;
    localparam logic [3:0] SRC_PIN3   = 4'hB;
    localparam logic [3:0] PIN_RISE   = 4'h0;
    localparam logic [3:0] PIN_FALL   = 4'h1;

    localparam int NUM_PINS  = 4;
    localparam int NUM_OUTS  = 3;
    localparam int APPLY_CYC = 2;

    typedef enum logic [2:0] {
        OPAS_WAIT_ARM = 3'b001,
        OPAS_ARMED    = 3'b010,
        OPAS_APPLY    = 3'b100
    } opas_state_t;

endpackage

// ### rtl/opas_sync_edge.sv
`timescale 1ns/1ps
module opas_sync_edge (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic ce_in,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic meta;
    logic sync;
    logic prev;

    // ------------------------------------------------------------
    // Two-flop synchroniser, edge detect on second stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else if (ce_in) begin
            meta <= async_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_out = sync;
    assign rise_out  = sync & ~prev;
    assign fall_out  = ~sync & prev;
endmodule

// ### rtl/opas_event_sel.sv
`timescale 1ns/1ps
module opas_event_sel
(
    input  wire logic [3:0]                    code_in,
    input  wire logic                          soft_in,
    input  wire logic                          pll_rise_in,
    input  wire logic [opas_pkg::NUM_PINS-1:0] pin_rise_in,
    input  wire logic [opas_pkg::NUM_PINS-1:0] pin_fall_in,
    input  wire logic [15:0]                   pin_cfg_in,
    input  wire logic                          pll_code_in,
    output logic                               event_out,
    output logic                               valid_out
);
    import opas_pkg::*;
    // ------------------------------------------------------------
    // Source select; pin edge sense from its function code
    // ------------------------------------------------------------
    logic [1:0] pin_idx;
    logic [3:0] pin_code;
    logic       is_pin;
    logic       pin_ev;

    assign pin_idx  = code_in[1:0];
    assign is_pin   = (code_in >= SRC_PIN0) && (code_in <= SRC_PIN3);
    assign pin_code = pin_cfg_in[{pin_idx, 2'b00} +: 4];
    assign pin_ev   = (pin_code == PIN_RISE) ? pin_rise_in[pin_idx] :   // [RL15]
                      (pin_code == PIN_FALL) ? pin_fall_in[pin_idx] : 1'b0;  // [RL17]
    assign event_out = is_pin ? pin_ev : (pll_code_in ? pll_rise_in : soft_in);
    // A pin programmed as an output never yields an event
    assign valid_out = ~is_pin | (pin_code == PIN_RISE) | (pin_code == PIN_FALL);   // [RL17]
endmodule

// ### rtl/opas_top.sv
// How it works
// [RL1] Writing one to reset bit aborts armed state, returns to wait; bit self-clears.
// [RL2] Software trigger bit starts adjustment when selected and armed; self-clears.
// [RL3] Software sets arm bit before trigger bit, in separate writes.
// [RL4] Software clears a stuck trigger bit in fast-divider corner cases.
// [RL5] Software arm bit arms when armed flag is zero; self-clears.
// [RL6] Writing zero to arm bit, or arming while armed, does nothing.
// [RL7] Polarity bit selects normal or inverted trigger signal.
// [RL8] Mode zero resets participating dividers, then applies phase offsets.
// [RL9] Mode one keeps dividers running, shifts each output by its offset.
// [RL10] Arm source: always, soft bit, PLL lock rise, pin 0..3 transitions.
// [RL11] Unused arm source codes are not programmed; device flags them.
// [RL12] Software resets sequencer after config changes in always-armed mode.
// [RL13] Trigger source: soft bit, PLL lock rise, pin 0..3; others unused.
// [RL14] Triggers ignored while unarmed; armed trigger starts the event.
// [RL15] Pin code 0000 detects rising edge, 0001 detects falling edge.
// [RL16] Interrupt high when any sticky status bit is set and enabled.
// [RL17] Pin code 0000 plain input, 0001 inverted input.
// [RL18] Pin and PLL lock inputs are synchronised and edge detected.
// [RL19] After adjustment, return to wait and clear armed unless always armed.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module opas_top
#(
    parameter int NOUT = opas_pkg::NUM_OUTS
) (
    input  wire logic                          clk_in,
    input  wire logic                          rstn_in,
    input  wire logic                          ce_in,
    input  wire logic                          wb_cyc_in,
    input  wire logic                          wb_stb_in,
    input  wire logic                          wb_we_in,
    input  wire logic [9:0]                    wb_adr_in,
    input  wire logic [3:0]                    wb_sel_in,
    input  wire logic [31:0]                   wb_dat_in,
    output logic      [31:0]                   wb_dat_out,
    output logic                               wb_ack_out,
    input  wire logic                          pll_lock_in,
    input  wire logic [opas_pkg::NUM_PINS-1:0] pin_in,
    output logic      [NOUT-1:0]               div_reset_out,
    output logic      [NOUT-1:0]               phase_apply_out,
    output logic                               adjust_relative_out,
    output logic                               irq_out
);
    import opas_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rstn;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rstn     <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rstn     <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic                pll_rise;
    logic [NUM_PINS-1:0] pin_rise;
    logic [NUM_PINS-1:0] pin_fall;

    opas_sync_edge u_pll_sync (   // [RL18]
        .clk_in    (clk_in),
        .rstn_in   (rstn),
        .ce_in     (ce_in),
        .async_in  (pll_lock_in),
        .level_out (),
        .rise_out  (pll_rise),
        .fall_out  ()
    );

    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        opas_sync_edge u_pin_sync (   // [RL18]
            .clk_in    (clk_in),
            .rstn_in   (rstn),
            .ce_in     (ce_in),
            .async_in  (pin_in[g]),
            .level_out (),
            .rise_out  (pin_rise[g]),
            .fall_out  (pin_fall[g])
        );
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]      ctrl;
    logic [7:0]      src;
    logic [15:0]     pin_cfg;
    logic [NOUT-1:0] partic;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    opas_state_t     state;
    logic [1:0]      apply_cnt;

    logic [3:0] arm_code;
    logic [3:0] trg_code;
    assign arm_code = src[SRC_ARM_LSB +: 4];
    assign trg_code = src[SRC_TRG_LSB +: 4];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire wr_req   = bus_req & wb_we_in & wb_sel_in[0];
    wire wr_ctrl  = wr_req & (wb_adr_in == ADDR_CTRL);
    wire wr_src   = wr_req & (wb_adr_in == ADDR_SRC);
    wire wr_stat  = wr_req & (wb_adr_in == ADDR_STATUS);
    wire wr_mask  = wr_req & (wb_adr_in == ADDR_MASK);
    wire wr_pcfg  = wr_req & (wb_adr_in == ADDR_PINCFG);
    wire wr_part  = wr_req & (wb_adr_in == ADDR_PARTIC);
    wire wr_pcfg1 = wr_pcfg & wb_sel_in[1];

    wire sw_rst   = wr_ctrl & wb_dat_in[CTRL_RST_BIT];    // [RL1]
    wire sw_soft_trigger_bit  = wr_ctrl & wb_dat_in[CTRL_SOFT_TRIGGER_BIT_BIT];
    wire sw_arm   = wr_ctrl & wb_dat_in[CTRL_ARM_BIT];    // [RL6]

    // ------------------------------------------------------------
    // Arm and trigger selection
    // ------------------------------------------------------------
    logic arm_sel_ev;
    logic trg_sel_ev;
    logic arm_valid;
    logic trg_valid;

    opas_event_sel u_arm_sel (   // [RL10]
        .code_in     (arm_code),
        .soft_in     (sw_arm & (arm_code == ARM_SOFT)),
        .pll_rise_in (pll_rise),
        .pin_rise_in (pin_rise),
        .pin_fall_in (pin_fall),
        .pin_cfg_in  (pin_cfg),
        .pll_code_in (arm_code == SRC_PLL_A),
        .event_out   (arm_sel_ev),
        .valid_out   (arm_valid)
    );

    opas_event_sel u_trg_sel (   // [RL13]
        .code_in     (trg_code),
        .soft_in     (sw_soft_trigger_bit & (trg_code == TRG_SOFT)),
        .pll_rise_in (pll_rise),
        .pin_rise_in (pin_rise),
        .pin_fall_in (pin_fall),
        .pin_cfg_in  (pin_cfg),
        .pll_code_in (trg_code == SRC_PLL_T),
        .event_out   (trg_sel_ev),
        .valid_out   (trg_valid)
    );

    // Unused source codes never fire and raise the bad-code flag
    wire arm_code_ok = (arm_code <= SRC_PLL_A) ||
                       ((arm_code >= SRC_PIN0) && (arm_code <= SRC_PIN3));   // [RL11]
    wire trg_code_ok = (trg_code <= SRC_PLL_T) ||
                       ((trg_code >= SRC_PIN0) && (trg_code <= SRC_PIN3));   // [RL13]
    wire always_arm  = (arm_code == ARM_ALWAYS);
    wire arm_ev      = arm_valid & arm_code_ok & arm_sel_ev;
    // Inverted polarity fires on the trailing edge of the selected event pulse, one cycle after normal polarity
    wire trg_raw     = trg_valid & trg_code_ok & trg_sel_ev;
    logic trg_prev;
    wire trg_ev      = ctrl[CTRL_TRIGGER_POLARITY_INVERT_BIT] ? (~trg_raw & trg_prev) : trg_raw;   // [RL7]

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    opas_state_t next_state;
    logic        armed;
    assign armed = (state == OPAS_ARMED);

    always_comb begin
        next_state = state;
        case (state)
            OPAS_WAIT_ARM: begin
                if (always_arm || arm_ev) begin   // [RL5]
                    next_state = OPAS_ARMED;
                end
            end
            OPAS_ARMED: begin
                if (trg_ev) begin   // [RL14]
                    next_state = OPAS_APPLY;
                end
            end
            OPAS_APPLY: begin
                if (apply_cnt == 2'(APPLY_CYC - 1)) begin
                    next_state = always_arm ? OPAS_ARMED : OPAS_WAIT_ARM;   // [RL19]
                end
            end
            default: next_state = OPAS_WAIT_ARM;
        endcase
        if (sw_rst) begin
            next_state = OPAS_WAIT_ARM;   // [RL1]
        end
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            state     <= OPAS_WAIT_ARM;
            apply_cnt <= 2'h0;
            trg_prev  <= 1'b0;
        end else if (ce_in) begin
            state     <= next_state;
            trg_prev  <= trg_raw;
            apply_cnt <= (state == OPAS_APPLY) ? apply_cnt + 2'h1 : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Divider and phase controls
    // ------------------------------------------------------------
    wire apply_first = (state == OPAS_APPLY) && (apply_cnt == 2'h0);
    wire apply_last  = (state == OPAS_APPLY) && (apply_cnt == 2'(APPLY_CYC - 1));
    wire align_mode  = ~ctrl[CTRL_MODE_BIT];

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            div_reset_out       <= '0;
            phase_apply_out     <= '0;
            adjust_relative_out <= 1'b0;
        end else if (ce_in) begin
            div_reset_out       <= (apply_first && align_mode) ? partic : '0;   // [RL8]
            phase_apply_out     <= apply_last ? partic : '0;                    // [RL9]
            adjust_relative_out <= ctrl[CTRL_MODE_BIT];                         // [RL9]
        end
    end

    // ------------------------------------------------------------
    // Register writes and status
    // ------------------------------------------------------------
    logic [ST_W-1:0] ev_set;
    assign ev_set = {(~arm_code_ok | ~trg_code_ok),
                     (state == OPAS_APPLY) && (next_state != OPAS_APPLY),
                     (state != OPAS_ARMED) && (next_state == OPAS_ARMED),
                     1'b0};

    // Trigger bit self-clears on the cycle after the write that set it, unless another ctrl write comes first
    wire soft_trigger_bit_done = ctrl[CTRL_SOFT_TRIGGER_BIT_BIT] & ~(wr_ctrl & wb_dat_in[CTRL_SOFT_TRIGGER_BIT_BIT]);

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            ctrl    <= CTRL_RESET;
            src     <= SRC_RESET;
            pin_cfg <= 16'h0000;
            partic  <= '0;
            mask    <= '0;
            status  <= '0;
        end else if (ce_in) begin
            if (wr_ctrl) begin
                ctrl <= {1'b0, wb_dat_in[CTRL_SOFT_TRIGGER_BIT_BIT] & armed & (trg_code == TRG_SOFT),
                         1'b0, 3'h0, wb_dat_in[1:0]};   // [RL2]
            end else if (soft_trigger_bit_done) begin
                ctrl[CTRL_SOFT_TRIGGER_BIT_BIT] <= 1'b0;            // [RL2]
            end
            if (wr_src) begin
                src <= wb_dat_in[7:0];
            end
            if (wr_pcfg) begin
                pin_cfg[7:0] <= wb_dat_in[7:0];
            end
            if (wr_pcfg1) begin
                pin_cfg[15:8] <= wb_dat_in[15:8];
            end
            if (wr_part) begin
                partic <= wb_dat_in[NOUT-1:0];
            end
            if (wr_mask) begin
                mask <= wb_dat_in[ST_W-1:0];
            end
            // Set wins over write-one-to-clear
            status <= (status & ~(wr_stat ? wb_dat_in[ST_W-1:0] : '0)) | ev_set;
        end
    end

    // ------------------------------------------------------------
    // Read path and interrupt
    // ------------------------------------------------------------
    logic [ST_W-1:0] status_view;
    assign status_view = {status[ST_W-1:1], armed};

    logic [31:0] rd_mux;
    assign rd_mux = (wb_adr_in == ADDR_CTRL)   ? {24'h0, ctrl}                :
                    (wb_adr_in == ADDR_SRC)    ? {24'h0, src}                 :
                    (wb_adr_in == ADDR_STATUS) ? {28'h0, status_view}         :
                    (wb_adr_in == ADDR_MASK)   ? {28'h0, mask}                :
                    (wb_adr_in == ADDR_PINCFG) ? {16'h0, pin_cfg}             :
                    (wb_adr_in == ADDR_PARTIC) ? {{(32-NOUT){1'b0}}, partic}  : 32'h0;

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
            irq_out    <= 1'b0;
        end else if (ce_in) begin
            wb_ack_out <= bus_req;
            wb_dat_out <= bus_req ? rd_mux : 32'h0;
            irq_out    <= |(status[ST_W-1:1] & mask[ST_W-1:1]);   // [RL16]
        end
    end
endmodule

// ### testbench/opas_assertions.sv
`timescale 1ns/1ps
module opas_assertions
#(
    parameter int NOUT = opas_pkg::NUM_OUTS
) (
    input  wire logic            clk_in,
    input  wire logic            rstn_in,
    input  wire logic            ce_in,
    input  wire logic            wb_cyc_in,
    input  wire logic            wb_stb_in,
    input  wire logic            wb_we_in,
    input  wire logic [9:0]      wb_adr_in,
    input  wire logic [3:0]      wb_sel_in,
    input  wire logic [31:0]     wb_dat_in,
    input  wire logic [31:0]     wb_dat_out,
    input  wire logic            wb_ack_out,
    input  wire logic [NOUT-1:0] div_reset_out,
    input  wire logic [NOUT-1:0] phase_apply_out,
    input  wire logic            adjust_relative_out,
    input  wire logic            irq_out
);
    import opas_pkg::*;
    // ----------
    // Bus
    // ----------
    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_ack_answer;
        wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_once;
        wb_ack_out && ce_in |=> !wb_ack_out;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_cause;
        $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_idle;
        !wb_ack_out |-> wb_dat_out == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    // ----------
    // Sequencer
    // ----------
    property p_div_then_apply;
        |div_reset_out && ce_in |=> phase_apply_out == $past(div_reset_out);
    endproperty
    a_div_then_apply: assert property (p_div_then_apply) else $error("no apply after reset");
    property p_div_mode0;
        |div_reset_out |-> !adjust_relative_out;
    endproperty
    a_div_mode0: assert property (p_div_mode0) else $error("divider reset in mode one");
    property p_apply_once;
        |phase_apply_out && ce_in |=> phase_apply_out == '0;
    endproperty
    a_apply_once: assert property (p_apply_once) else $error("apply pulse too long");
    property p_mode_write;
        $changed(adjust_relative_out) |-> (wb_ack_out && wb_we_in && wb_adr_in == ADDR_CTRL)
            || $past(wb_ack_out && wb_we_in && wb_adr_in == ADDR_CTRL);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode changed unasked");
    property p_irq_mask;
        wb_ack_out && wb_we_in && wb_adr_in == ADDR_MASK && wb_sel_in[0] && ce_in
            && wb_dat_in[3:1] == 3'h0 |=> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
    c_align: cover property (|div_reset_out);
    c_adjust: cover property (|phase_apply_out && adjust_relative_out);
    c_irq: cover property ($rose(irq_out));
endmodule

bind opas_top opas_assertions #(.NOUT(NOUT)) opas_assertions_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .div_reset_out(div_reset_out),
    .phase_apply_out(phase_apply_out), .adjust_relative_out(adjust_relative_out),
    .irq_out(irq_out)
);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import opas_pkg::*;
    // ----------
    // Design
    // ----------
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        wb_cyc_in = 1'b0;
    logic        wb_stb_in = 1'b0;
    logic        wb_we_in = 1'b0;
    logic [9:0]  wb_adr_in = '0;
    logic [3:0]  wb_sel_in = '0;
    logic [31:0] wb_dat_in = '0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        pll_lock_in = 1'b0;
    logic [3:0]  pin_in = '0;
    logic [2:0]  div_reset_out;
    logic [2:0]  phase_apply_out;
    logic        adjust_relative_out;
    logic        irq_out;
    logic [2:0]  last_div = '0;
    logic [2:0]  last_app = '0;
    logic [31:0] d;
    logic        lv;
    logic [7:0]  bad_src [8] = '{8'h30, 8'h70, 8'hC0, 8'hF0, 8'h12, 8'h17, 8'h1C, 8'h1F};
    int          n_div = 0;
    int          n_app = 0;
    int          cyc_cnt = 0;
    int          app_cyc = 0;
    int          t0 = 0;
    int          lat_n;
    int          n0;
    int          m0;
    int          fail_count = 0;
    int          n_compared = 0;

    always #50 clk_in = ~clk_in;

    opas_top #(.NOUT(3)) opas_top_inst (
        .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .pll_lock_in(pll_lock_in), .pin_in(pin_in),
        .div_reset_out(div_reset_out), .phase_apply_out(phase_apply_out),
        .adjust_relative_out(adjust_relative_out), .irq_out(irq_out)
    );

    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (|div_reset_out) begin
            n_div <= n_div + 1;
            last_div <= div_reset_out;
        end
        if (|phase_apply_out) begin
            n_app <= n_app + 1;
            last_app <= phase_apply_out;
            app_cyc <= cyc_cnt;
        end
    end
    // ----------
    // Tasks
    // ----------
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic we, input logic [9:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_sel_in <= 4'hF;
        wb_adr_in <= a;
        wb_dat_in <= wd;
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        d = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check_val(d & m, e);
    endtask

    task automatic await(input int c);
        for (int i = 0; i < 30 && n_app == c; i++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
    endtask

    task automatic drive_src(input int k, input logic v);
        @(posedge clk_in);
        if (k < 4) pin_in[k] <= v;
        else pll_lock_in <= v;
        t0 = cyc_cnt;
        await(n_app);
    endtask

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk_in);
        check_val(irq_out, e);
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        complete_run();
    end
    // ----------
    // Tests
    // ----------
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rdchk(ADDR_CTRL, 32'hFF, 32'h0);
        rdchk(ADDR_SRC, 32'hFF, 32'h0);
        wr(ADDR_PARTIC, 32'h7);
        wr(ADDR_MASK, 32'hE);
        wr(ADDR_SRC, {24'h0, ARM_SOFT, TRG_SOFT});
        wr(ADDR_CTRL, 32'h80);
        wr(ADDR_CTRL, 32'h0);
        rdchk(ADDR_STATUS, 32'h1, 32'h0);
        n0 = n_app;
        wr(ADDR_CTRL, 32'h40);
        await(n0);
        check_val(n_app - n0, 0);
        wr(ADDR_CTRL, 32'h20);
        rdchk(ADDR_STATUS, 32'h1, 32'h1);
        rdchk(ADDR_CTRL, 32'hFF, 32'h0);
        wr(ADDR_CTRL, 32'h80);
        rdchk(ADDR_STATUS, 32'h1, 32'h0);
        wr(ADDR_CTRL, 32'h40);
        await(n0);
        check_val(n_app - n0, 0);
        wr(ADDR_CTRL, 32'h20);
        wr(ADDR_CTRL, 32'h40);
        await(n0);
        check_val(n_app - n0, 1);
        check_val(last_div, 3'h7);
        check_val(last_app, 3'h7);
        rdchk(ADDR_STATUS, 32'h5, 32'h4);
        rdchk(ADDR_CTRL, 32'h40, 32'h0);
        chk_irq(1'b1);
        wr(ADDR_MASK, 32'h0);
        chk_irq(1'b0);
        wr(ADDR_MASK, 32'hE);
        chk_irq(1'b1);
        wr(ADDR_STATUS, 32'hE);
        chk_irq(1'b0);
        wr(ADDR_CTRL, 32'h21);
        n0 = n_app;
        m0 = n_div;
        wr(ADDR_CTRL, 32'h41);
        await(n0);
        check_val(n_app - n0, 1);
        check_val(n_div - m0, 0);
        check_val(adjust_relative_out, 1'b1);
        for (int k = 0; k < 5; k++) begin
            lv = (k % 2 == 1) && (k < 4);
            drive_src(k, lv);
            wr(ADDR_PINCFG, 32'(k % 2) << (4 * k));
            wr(ADDR_SRC, k < 4 ? {24'h0, 4'h8 + 4'(k), 4'h8 + 4'(k)}
                               : {24'h0, SRC_PLL_A, SRC_PLL_T});
            wr(ADDR_CTRL, 32'h80);
            n0 = n_app;
            drive_src(k, !lv);
            rdchk(ADDR_STATUS, 32'h1, 32'h1);
            drive_src(k, lv);
            check_val(n_app - n0, 0);
            drive_src(k, !lv);
            check_val(n_app - n0, 1);
            drive_src(k, lv);
        end
        wr(ADDR_PINCFG, 32'h0);
        wr(ADDR_SRC, {24'h0, ARM_ALWAYS, SRC_PIN0});
        wr(ADDR_CTRL, 32'h80);
        rdchk(ADDR_STATUS, 32'h1, 32'h1);
        drive_src(0, 1'b1);
        lat_n = app_cyc - t0;
        rdchk(ADDR_STATUS, 32'h1, 32'h1);
        drive_src(0, 1'b0);
        wr(ADDR_CTRL, 32'h82);
        n0 = n_app;
        drive_src(0, 1'b1);
        check_val(n_app - n0, 1);
        check_val(app_cyc - t0, lat_n + 1);
        drive_src(0, 1'b0);
        foreach (bad_src[i]) begin
            wr(ADDR_SRC, {24'h0, bad_src[i]});
            rdchk(ADDR_SRC, 32'hFF, {24'h0, bad_src[i]});
            rdchk(ADDR_STATUS, 32'h8, 32'h8);
            wr(ADDR_SRC, 32'h10);
            wr(ADDR_STATUS, 32'h8);
            rdchk(ADDR_STATUS, 32'h8, 32'h0);
        end
        wr(10'h200, 32'hFF);
        rdchk(10'h200, 32'hFFFFFFFF, 32'h0);
        complete_run();
    end
endmodule
